// ### shared/acmp_regs.vh
// Purpose: register map and field layout of the comparator control block
// Assumes: 32-bit AXI4-Lite data, one 8-bit register per aligned word
// Notes:   offsets are word indices; byte address is four times the index
`ifndef ACMP_REGS_VH
`define ACMP_REGS_VH

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define ACMP_IDX_CTRL_STATUS 10'h030
`define ACMP_IDX_PIN_DISABLE 10'h07F
`define ACMP_IDX_CONV_CTRL_B 10'h031
`define ACMP_IDX_CONV_MIRROR 10'h032
`define ACMP_IDX_IRQ_MASK 10'h033
`define ACMP_ADDR_W 12

// ------------------------------------------------------------
// comparator_control_status fields
// ------------------------------------------------------------
`define ACMP_CS_DISABLE 7
`define ACMP_CS_BANDGAP 6
`define ACMP_CS_OUTPUT 5
`define ACMP_CS_FLAG 4
`define ACMP_CS_IRQ_EN 3
`define ACMP_CS_CAPTURE 2
`define ACMP_CS_MODE_HI 1
`define ACMP_CS_MODE_LO 0
`define ACMP_CS_RW_MASK 8'hCF
`define ACMP_CS_RESET 8'h00

// ------------------------------------------------------------
// other registers
// ------------------------------------------------------------
`define ACMP_PD_NEG 1
`define ACMP_PD_POS 0
`define ACMP_PD_RW_MASK 8'h03
`define ACMP_PD_RESET 8'h00
`define ACMP_CB_MUX_EN 6
`define ACMP_CB_RW_MASK 8'h40
`define ACMP_CB_RESET 8'h00
`define ACMP_CM_CONV_EN 7
`define ACMP_CM_CHAN_HI 2
`define ACMP_CM_RW_MASK 8'h87
`define ACMP_CM_RESET 8'h00
`define ACMP_IM_RW_MASK 8'h10
`define ACMP_IM_RESET 8'h10

// ------------------------------------------------------------
// interrupt modes
// ------------------------------------------------------------
`define ACMP_MODE_TOGGLE 2'h0
`define ACMP_MODE_RSVD 2'h1
`define ACMP_MODE_FALL 2'h2
`define ACMP_MODE_RISE 2'h3

`define ACMP_RESP_OKAY 2'h0
`define ACMP_RESP_SLVERR 2'h2

`endif

// ### hdl/acmp_sync.v
// Purpose: two-stage synchroniser for the asynchronous comparator output
// Assumes: single clock aclk, synchronous active-low reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module acmp_sync (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// data
	input wire async_in,
	output reg sync_out_r
);

	reg meta_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= 1'b0;
			sync_out_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_out_r <= meta_r;
		end
	end

endmodule // acmp_sync

// ### hdl/acmp_ctrl.v
// Purpose: digital control around the on-chip analog voltage comparator
// Assumes: AXI4-Lite register access, one clock aclk at 100 MHz
// Notes:   analog core and timer capture unit sit outside this module
`timescale 1ns/1ps
`include "acmp_regs.vh"

module acmp_ctrl (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [`ACMP_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [`ACMP_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// analog comparator core
	input wire comparator_raw,
	output reg comparator_power_off_r,
	output reg bandgap_select_r,
	output reg neg_use_channel_r,
	output reg [2:0] channel_select_r,
	// comparator pins, digital side
	input wire [1:0] pin_raw,
	output reg [1:0] pin_buffer_off_r,
	output reg [1:0] pin_read_r,
	// timer input capture front end
	output reg capture_route_enable_r,
	output reg capture_in_r,
	// interrupt
	input wire global_irq_enable,
	input wire irq_vector_ack,
	output reg irq_r
);

	// ------------------------------------------------------------
	// state encodings
	// ------------------------------------------------------------
	localparam [1:0] WR_IDLE = 2'b01;
	localparam [1:0] WR_RESP = 2'b10;
	localparam [1:0] RD_IDLE = 2'b01;
	localparam [1:0] RD_DATA = 2'b10;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	reg [7:0] ctrl_r;
	reg [7:0] pin_dis_r;
	reg [7:0] conv_b_r;
	reg [7:0] conv_mirror_r;
	reg [7:0] irq_mask_r;
	reg flag_r;
	reg flag_nxt;
	reg out_prev_r;
	reg [1:0] wr_state_r;
	reg [1:0] rd_state_r;
	reg aw_got_r;
	reg w_got_r;
	reg [`ACMP_ADDR_W-1:0] aw_addr_r;
	reg [7:0] w_data_r;
	reg w_lane0_r;
	reg event_hit;
	reg [7:0] rd_byte;
	reg rd_ok;
	reg wr_ok;
	reg [7:0] ctrl_view;
	wire comp_sync;
	wire do_write;
	wire [9:0] wr_idx;
	wire [9:0] rd_idx;
	wire wr_aligned;
	wire rd_aligned;
	wire flag_w1c;
	wire [1:0] mode;
	wire [1:0] pin_gated;

	// ------------------------------------------------------------
	// comparator output synchroniser
	// ------------------------------------------------------------
	acmp_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(comparator_raw),
		.sync_out_r(comp_sync)
	);

	// ------------------------------------------------------------
	// event detection and interrupt flag
	// ------------------------------------------------------------
	assign mode = {ctrl_r[`ACMP_CS_MODE_HI], ctrl_r[`ACMP_CS_MODE_LO]};

	always @* begin
		case (mode)
			`ACMP_MODE_TOGGLE: event_hit = comp_sync ^ out_prev_r;
			`ACMP_MODE_FALL: event_hit = out_prev_r & ~comp_sync;
			`ACMP_MODE_RISE: event_hit = ~out_prev_r & comp_sync;
			default: event_hit = 1'b0;
		endcase
	end

	// a write is only seen through lane 0, the byte that holds the flag
	assign flag_w1c = do_write && w_lane0_r && wr_ok &&
		(wr_idx == `ACMP_IDX_CTRL_STATUS) && w_data_r[`ACMP_CS_FLAG];

	always @* begin
		flag_nxt = flag_r;
		if (flag_w1c || irq_vector_ack) begin
			flag_nxt = 1'b0;
		end
		if (event_hit) begin
			flag_nxt = 1'b1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 1'b0;
			out_prev_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			out_prev_r <= comp_sync;
			// mask bit is the same bit position as the flag
			irq_r <= flag_nxt & ctrl_r[`ACMP_CS_IRQ_EN] & global_irq_enable &
				irq_mask_r[`ACMP_CS_FLAG];
		end
	end

	// ------------------------------------------------------------
	// analog and capture controls
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			comparator_power_off_r <= 1'b0;
			bandgap_select_r <= 1'b0;
			neg_use_channel_r <= 1'b0;
			channel_select_r <= 3'h0;
			capture_route_enable_r <= 1'b0;
			capture_in_r <= 1'b0;
		end else begin
			comparator_power_off_r <= ctrl_r[`ACMP_CS_DISABLE];
			bandgap_select_r <= ctrl_r[`ACMP_CS_BANDGAP];
			// converter owns the mux while it runs, so the pin takes over
			neg_use_channel_r <= conv_b_r[`ACMP_CB_MUX_EN] &
				~conv_mirror_r[`ACMP_CM_CONV_EN];
			channel_select_r <= conv_mirror_r[`ACMP_CM_CHAN_HI:0];
			capture_route_enable_r <= ctrl_r[`ACMP_CS_CAPTURE];
			// forced low, not held, so a disabled route cannot leave an edge behind
			capture_in_r <= ctrl_r[`ACMP_CS_CAPTURE] & comp_sync;
		end
	end

	// ------------------------------------------------------------
	// pin digital input gating
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
			assign pin_gated[gi] = pin_raw[gi] & ~pin_dis_r[gi];
			always @(posedge aclk) begin
				if (!aresetn) begin
					pin_buffer_off_r[gi] <= 1'b0;
					pin_read_r[gi] <= 1'b0;
				end else begin
					pin_buffer_off_r[gi] <= pin_dis_r[gi];
					pin_read_r[gi] <= pin_gated[gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	assign wr_idx = aw_addr_r[`ACMP_ADDR_W-1:2];
	assign wr_aligned = (aw_addr_r[1:0] == 2'h0);
	assign do_write = (wr_state_r == WR_IDLE) && aw_got_r && w_got_r;

	always @* begin
		case (wr_idx)
			`ACMP_IDX_CTRL_STATUS,
			`ACMP_IDX_PIN_DISABLE,
			`ACMP_IDX_CONV_CTRL_B,
			`ACMP_IDX_CONV_MIRROR,
			`ACMP_IDX_IRQ_MASK: wr_ok = wr_aligned;
			default: wr_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_r <= WR_IDLE;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= {`ACMP_ADDR_W{1'b0}};
			w_data_r <= 8'h00;
			w_lane0_r <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ACMP_RESP_OKAY;
		end else begin
			case (wr_state_r)
				WR_IDLE: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_addr_r <= s_axi_awaddr;
						aw_got_r <= 1'b1;
						s_axi_awready <= 1'b0;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_data_r <= s_axi_wdata[7:0];
						w_lane0_r <= s_axi_wstrb[0];
						w_got_r <= 1'b1;
						s_axi_wready <= 1'b0;
					end
					if (do_write) begin
						aw_got_r <= 1'b0;
						w_got_r <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= wr_ok ? `ACMP_RESP_OKAY : `ACMP_RESP_SLVERR;
						wr_state_r <= WR_RESP;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						wr_state_r <= WR_IDLE;
					end
				end
				default: begin
					wr_state_r <= WR_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `ACMP_CS_RESET;
			pin_dis_r <= `ACMP_PD_RESET;
			conv_b_r <= `ACMP_CB_RESET;
			conv_mirror_r <= `ACMP_CM_RESET;
			irq_mask_r <= `ACMP_IM_RESET;
		end else if (do_write && wr_ok && w_lane0_r) begin
			case (wr_idx)
				`ACMP_IDX_CTRL_STATUS: begin
					// flag and output bits are not stored here
					ctrl_r <= w_data_r & `ACMP_CS_RW_MASK;
				end
				`ACMP_IDX_PIN_DISABLE: begin
					pin_dis_r <= w_data_r & `ACMP_PD_RW_MASK;
				end
				`ACMP_IDX_CONV_CTRL_B: begin
					conv_b_r <= w_data_r & `ACMP_CB_RW_MASK;
				end
				`ACMP_IDX_CONV_MIRROR: begin
					conv_mirror_r <= w_data_r & `ACMP_CM_RW_MASK;
				end
				`ACMP_IDX_IRQ_MASK: begin
					irq_mask_r <= w_data_r & `ACMP_IM_RW_MASK;
				end
				default: begin
					ctrl_r <= ctrl_r;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	assign rd_idx = s_axi_araddr[`ACMP_ADDR_W-1:2];
	assign rd_aligned = (s_axi_araddr[1:0] == 2'h0);

	always @* begin
		ctrl_view = ctrl_r;
		ctrl_view[`ACMP_CS_OUTPUT] = comp_sync;
		ctrl_view[`ACMP_CS_FLAG] = flag_r;
		rd_ok = rd_aligned;
		case (rd_idx)
			`ACMP_IDX_CTRL_STATUS: rd_byte = ctrl_view;
			`ACMP_IDX_PIN_DISABLE: rd_byte = pin_dis_r & `ACMP_PD_RW_MASK;
			`ACMP_IDX_CONV_CTRL_B: rd_byte = conv_b_r;
			`ACMP_IDX_CONV_MIRROR: rd_byte = conv_mirror_r;
			`ACMP_IDX_IRQ_MASK: rd_byte = irq_mask_r;
			default: begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_r <= RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ACMP_RESP_OKAY;
		end else begin
			case (rd_state_r)
				RD_IDLE: begin
					if (s_axi_arvalid) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
						s_axi_rresp <= rd_ok ? `ACMP_RESP_OKAY : `ACMP_RESP_SLVERR;
						rd_state_r <= RD_DATA;
					end
				end
				RD_DATA: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						s_axi_arready <= 1'b1;
						rd_state_r <= RD_IDLE;
					end
				end
				default: begin
					rd_state_r <= RD_IDLE;
				end
			endcase
		end
	end

	// software ordering of enable versus mode or disable changes is not
	// checked here; a spurious edge during such a change sets the flag
	// as any other event would

endmodule // acmp_ctrl

// ### verification/acmp_analog_model.sv
// Purpose: analog comparator core and timer capture front end
// Assumes: levels are unsigned codes, larger is higher voltage
// Notes:   powered off, the output rests low
`timescale 1ns/1ps

module acmp_analog_model #(
	parameter logic [7:0] BANDGAP_LEVEL = 8'h80
) (
	// control from the block
	input wire logic power_off,
	input wire logic bandgap,
	input wire logic use_channel,
	input wire logic [2:0] channel,
	input wire logic capture_in,
	// levels from the bench
	input wire logic [7:0] pos_level,
	input wire logic [7:0] neg_level,
	input wire logic [63:0] chan_levels,
	// results
	output logic comparator_raw,
	output int cap_edges
);
	logic [7:0] p, n;
	assign p = bandgap ? BANDGAP_LEVEL : pos_level;
	assign n = use_channel ? chan_levels[channel*8 +: 8] : neg_level;
	assign comparator_raw = !power_off && (p > n);
	initial cap_edges = 0;
	// edge select of the capture unit: rising edges only
	always @(posedge capture_in) cap_edges <= cap_edges + 1;
endmodule // acmp_analog_model

// ### verification/acmp_ctrl_asserts.sv
// Purpose: port checks of the comparator control block
// Assumes: one clock domain
// Notes:   bound into every acmp_ctrl
`timescale 1ns/1ps

module acmp_ctrl_asserts (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [31:0] s_axi_rdata,
	// comparator, pins, capture, interrupt
	input wire comparator_raw,
	input wire [1:0] pin_buffer_off_r,
	input wire [1:0] pin_read_r,
	input wire capture_route_enable_r,
	input wire capture_in_r,
	input wire global_irq_enable,
	input wire irq_vector_ack,
	input wire irq_r
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_cap_gated:
		assert property (!capture_route_enable_r && !$past(capture_route_enable_r)
			|-> !capture_in_r) else $error("capture live with route off");
	a_cap_follow:
		assert property (capture_route_enable_r && $past(capture_route_enable_r)
			|-> capture_in_r == $past(comparator_raw, 3)) else $error("capture lag wrong");
	a_pin_masked:
		assert property ((pin_buffer_off_r & $past(pin_buffer_off_r) & pin_read_r) == 2'h0)
			else $error("disabled pin reads one");
	a_irq_global:
		assert property (irq_r |-> $past(global_irq_enable)) else $error("irq without global");
	a_ack_clears:
		assert property ($stable(comparator_raw) [*5] ##0 irq_vector_ack |=> !irq_r)
			else $error("ack left irq up");
	a_write_answer:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> ##1 s_axi_bvalid) else $error("late write response");
	a_read_answer:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
			else $error("late read data");
	a_rdata_byte:
		assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
			else $error("upper read bits set");
endmodule // acmp_ctrl_asserts

bind acmp_ctrl acmp_ctrl_asserts i_acmp_ctrl_asserts (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .comparator_raw, .pin_buffer_off_r,
	.pin_read_r, .capture_route_enable_r, .capture_in_r, .global_irq_enable,
	.irq_vector_ack, .irq_r);

// ### verification/test_acmp_ctrl.sv
// Purpose: self-checking bench of the comparator control block
// Assumes: 100 MHz clock, AXI4-Lite master tasks
// Notes:   the analog side is a level model
`timescale 1ns/1ps
`include "acmp_regs.vh"

module test_acmp_ctrl;
	localparam [11:0] CS = `ACMP_IDX_CTRL_STATUS * 4;
	localparam [11:0] PD = `ACMP_IDX_PIN_DISABLE * 4;
	localparam [11:0] CB = `ACMP_IDX_CONV_CTRL_B * 4;
	localparam [11:0] CM = `ACMP_IDX_CONV_MIRROR * 4;
	localparam [11:0] IM = `ACMP_IDX_IRQ_MASK * 4;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, global_irq_enable = 1, irq_vector_ack = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_r;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, pin_raw = 0, pin_buffer_off_r, pin_read_r;
	logic [1:0] brsp;
	logic comparator_raw, comparator_power_off_r, bandgap_select_r, neg_use_channel_r;
	logic capture_route_enable_r, capture_in_r;
	logic [2:0] channel_select_r;
	logic [7:0] pos_level = 0;
	logic [63:0] chan_levels = 0;
	int num_errors = 0, checks = 0, cycles = 0, cap_edges, e0, n;
	bit f;

	acmp_ctrl i_acmp_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_raw,
		.comparator_power_off_r, .bandgap_select_r, .neg_use_channel_r, .channel_select_r,
		.pin_raw, .pin_buffer_off_r, .pin_read_r, .capture_route_enable_r, .capture_in_r,
		.global_irq_enable, .irq_vector_ack, .irq_r);
	acmp_analog_model i_acmp_analog_model (.power_off(comparator_power_off_r),
		.bandgap(bandgap_select_r), .use_channel(neg_use_channel_r),
		.channel(channel_select_r), .capture_in(capture_in_r), .pos_level,
		.neg_level(8'h80), .chan_levels, .comparator_raw, .cap_edges);

	// ------------------------------------------------------------
	// clock, watchdog, helpers
	// ------------------------------------------------------------
	initial forever #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			conclude;
		end
	end

	task automatic conclude;
		if (num_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input [31:0] got, input [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input [11:0] a, input [7:0] v);
		bit pa, pw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		pa = 1;
		pw = 1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && s_axi_awready) begin
				pa = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready) begin
				pw = 0;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		brsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rc(input [11:0] a, input [31:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(d, e);
	endtask

	// waits long enough for synchroniser, edge detect and irq
	task automatic lv(input bit hi);
		@(posedge aclk);
		pos_level <= hi ? 8'h81 + 8'($urandom % 127) : 8'($urandom % 128);
		repeat (6) @(posedge aclk);
	endtask

	function automatic bit exp_flag(input [1:0] m, input bit r);
		return m == `ACMP_MODE_TOGGLE || m == {1'b1, r};
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'hf2762c99));
		chan_levels = {$urandom, $urandom};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rc(CS, 0);
		rc(PD, 0);
		rc(IM, 8'h10);
		rc(12'h100, 0);
		chk(rsp, `ACMP_RESP_SLVERR);
		wr(12'h100, 8'hFF);
		chk(brsp, `ACMP_RESP_SLVERR);
		for (int i = 0; i < 32; i++) begin
			wr(CB, {1'b0, i[3], 6'h0});
			wr(CM, {i[4], 4'h0, i[2:0]});
			repeat (2) @(posedge aclk);
			chk(neg_use_channel_r, i[3] & ~i[4]);
			if (i[3] & ~i[4]) chk(channel_select_r, i[2:0]);
		end
		wr(CB, 8'h00);
		lv(1);
		wr(CS, 8'hC0);
		repeat (2) @(posedge aclk);
		chk({comparator_power_off_r, bandgap_select_r}, 2'h3);
		// earlier toggles in mode 00 have left the flag set
		rc(CS, 8'hD0);
		wr(CS, 8'h00);
		lv(0);
		for (int m = 0; m < 4; m++) begin
			wr(CS, m);
			wr(CS, 8'h10 | m);
			wr(CS, 8'h08 | m);
			for (int r = 1; r >= 0; r--) begin
				lv(r[0]);
				f = exp_flag(m[1:0], r[0]);
				rc(CS, {2'h0, r[0], f, 2'h2, m[1:0]});
				chk(irq_r, f);
				wr(CS, 8'h18 | m);
			end
			wr(CS, 8'h10 | m);
		end
		lv(1);
		wr(CS, 8'h0B);
		rc(CS, 8'h3B);
		chk(irq_r, 1);
		wr(IM, 8'h00);
		repeat (2) @(posedge aclk);
		chk(irq_r, 0);
		wr(IM, 8'h10);
		global_irq_enable <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(irq_r, 0);
		global_irq_enable <= 1'b1;
		irq_vector_ack <= 1'b1;
		@(posedge aclk);
		irq_vector_ack <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(irq_r, 0);
		rc(CS, 8'h2B);
		wr(CS, 8'h03);
		wr(CS, 8'h04);
		for (int k = 0; k < 2; k++) begin
			e0 = cap_edges;
			n = 3 + $urandom % 4;
			repeat (n) begin
				lv(1);
				lv(0);
			end
			chk(capture_route_enable_r, k == 0);
			chk(cap_edges - e0, k ? 0 : n);
			wr(CS, 8'h00);
		end
		wr(PD, 8'hFF);
		chk(brsp, `ACMP_RESP_OKAY);
		rc(PD, 8'h03);
		for (int k = 0; k < 6; k++) begin
			if (k == 3) wr(PD, 8'h01);
			@(posedge aclk);
			pin_raw <= 2'($urandom);
			repeat (4) @(posedge aclk);
			chk({pin_buffer_off_r, pin_read_r}, k < 3 ? 4'hC : {2'h1, pin_raw & 2'h2});
		end
		conclude;
	end
endmodule // test_acmp_ctrl
